/* File: acs_card_model.sv */
// far-side card model: takes command bytes and plays back replies
`timescale 1ns/100ps
module acs_card_model (
	// clock and pace
	input  wire logic       clk_i,
	input  wire logic       slow_i,
	// command bytes
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	// replies
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_last_o,
	output logic            rx_coll_o,
	output logic            rx_crc_err_o,
	output logic            rx_timeout_o
);
	logic [7:0] q[$];
	bit         fin = 1'b0;
	bit         rdy;

	initial begin
		tx_ready_o = 1'b0;
		{rx_valid_o, rx_last_o, rx_coll_o, rx_crc_err_o, rx_timeout_o} = 5'h00;
		rx_data_o = 8'h5a;
	end
	// a slow card accepts every other cycle, so the reader must hold its byte;
	// the byte is logged half a cycle later, away from the edge that launches it
	always @(negedge clk_i) begin
		rdy = slow_i ? ~tx_ready_o : 1'b1;
		tx_ready_o <= rdy;
		if (tx_valid_i && rdy) begin
			q.push_back(tx_data_i);
			fin |= tx_last_i;
		end
	end

	task send(input logic [7:0] b, input logic l, input logic c, input logic e);
		@(negedge clk_i);
		{rx_valid_o, rx_last_o, rx_coll_o, rx_crc_err_o} = {1'b1, l, c, e};
		rx_data_o = b;
		@(negedge clk_i);
		{rx_valid_o, rx_last_o, rx_coll_o, rx_crc_err_o} = 4'h0;
		// released data line shows the inverse, not the stale byte
		rx_data_o = ~b;
	endtask : send

	task mute;
		@(negedge clk_i);
		rx_timeout_o = 1'b1;
		@(negedge clk_i);
		rx_timeout_o = 1'b0;
	endtask : mute
endmodule : acs_card_model

/* File: acs_mem_if.sv */
// carrier between the sequencer and its identifier store
`timescale 1ns/100ps
interface acs_mem_if;
	logic       wr_en;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic [3:0] rd_addr;
	logic [7:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : acs_mem_if

/* File: acs_params.svh */
// constants of the anticollision and select sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_SEL_LVL1    8'h93
`define ACS_SEL_LVL2    8'h95
`define ACS_SEL_LVL3    8'h97
`define ACS_NVB_ANTI    8'h20
`define ACS_NVB_SEL     8'h70
`define ACS_CASCADE_TAG 8'h88
`define ACS_RATS_CMD    8'hE0
`define ACS_RATS_PARAM  8'h01
`define ACS_DESEL_CMD   8'hC2
`define ACS_SIZE_SINGLE 2'b00
`define ACS_SIZE_DOUBLE 2'b01
`define ACS_SIZE_TRIPLE 2'b10
`define ACS_SIZE_POS    6
`define ACS_CASC_BIT    2
`define ACS_UID_BITS    6'd32
`define ACS_LVL_BYTES   4'd5
`define ACS_ANTI_LEN    3'd2
`define ACS_SEL_LEN     3'd7
`define ACS_RATS_LEN    3'd2
`define ACS_DESEL_LEN   3'd1
`define ACS_RATS_TRIES  1'b1

`endif

/* File: acs_pkg.sv */
// types of the anticollision and select sequencer
package acs_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_TXF   = 4'b0001,
		ST_TXW   = 4'b0010,
		ST_TXL   = 4'b0011,
		ST_TXB   = 4'b0100,
		ST_RX    = 4'b0101,
		ST_WRB   = 4'b0110,
		ST_DONE  = 4'b0111,
		ST_FAIL  = 4'b1000
	} acs_state_t;

	typedef enum logic [2:0] {
		FR_ANTI  = 3'b000,
		FR_PART  = 3'b001,
		FR_SEL   = 3'b010,
		FR_RATS  = 3'b011,
		FR_DESEL = 3'b100
	} acs_frame_t;

endpackage : acs_pkg

/* File: acs_reader.sv */
// reader-side anticollision, select and answer-to-select sequencer
`timescale 1ns/100ps
`include "acs_params.svh"

// What this block does
// R1: answer to request b8 b7 give identifier size
// R2: level one starts with anticollision 93 20
// R3: single size: select 93 70, four bytes, check
// R4: tagged level one reply selected with 93 70 88
// R5: select acknowledge b3 is the cascade flag
// R6: cascade after level one sends 95 20
// R7: level two select with 95 70 or tagged
// R8: level three sends 97 20 then 97 70
// R9: card answers first anticollision fully colliding
// R10: send 93, NVB, k resolved bits per step
// R11: optional 93 60 full-length anticollision, skipped here
// R12: after resolution select 93 70, own check byte
// R13: silent answer to select: retry request once
// R14: still no valid answer: send deselect
// R15: bad CRC answer treated as silence
// R16: check byte is xor of four bytes
module acs_reader
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// answer to request from the framer
	input  wire logic       atqa_valid_i,
	input  wire logic [7:0] atqa_i,
	// command frames towards the framer
	output logic            tx_valid_o,
	output logic [7:0]      tx_data_o,
	output logic            tx_last_o,
	output logic [2:0]      tx_bits_o,
	output logic            tx_crc_o,
	input  wire logic       tx_ready_i,
	// card replies from the framer
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       rx_last_i,
	input  wire logic       rx_coll_i,
	input  wire logic       rx_crc_err_i,
	input  wire logic       rx_timeout_i,
	// result
	output logic            done_o,
	output logic            fail_o,
	output logic [1:0]      size_o
);

	typedef struct packed {
		acs_state_t st;
		acs_frame_t kind;
		logic [2:0] idx;
		logic [2:0] len;
		logic [1:0] lvl;
		logic [1:0] size;
		logic [5:0] k;
		logic [31:0] res;
		logic [7:0] bcc;
		logic       retried;
		logic       coll;
		logic       bad;
		logic       tx_valid;
		logic [7:0] tx_data;
		logic       tx_last;
		logic [2:0] tx_bits;
		logic       tx_crc;
		logic       done;
		logic       fail;
		logic       mwe;
		logic [3:0] mwa;
		logic [7:0] mwd;
		logic [3:0] mra;
	} acs_regs_t;

	acs_regs_t q, d;
	acs_mem_if mem_bus ();

	acs_uid_mem #(.DEPTH(16)) u_mem (
		.clk_i  (clk_i),
		.mem_if (mem_bus.mem)
	);

	assign mem_bus.wr_en   = q.mwe;
	assign mem_bus.wr_addr = q.mwa;
	assign mem_bus.wr_data = q.mwd;
	assign mem_bus.rd_addr = q.mra;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lvl_cmd(input logic [1:0] lvl);
		unique case (lvl)
			2'd0: lvl_cmd = `ACS_SEL_LVL1;
			2'd1: lvl_cmd = `ACS_SEL_LVL2; // R6 R7
			default: lvl_cmd = `ACS_SEL_LVL3; // R8
		endcase
	endfunction : lvl_cmd

	function automatic logic [3:0] lvl_base(input logic [1:0] lvl, input logic [2:0] idx);
		lvl_base = 4'(lvl * `ACS_LVL_BYTES) + 4'(idx);
	endfunction : lvl_base

	function automatic logic [7:0] xor4(input logic [31:0] w);
		xor4 = w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24]; // R16
	endfunction : xor4

	// byte count of a partial anticollision frame holding k bits
	function automatic logic [2:0] part_len(input logic [5:0] k);
		part_len = 3'd2 + 3'(k[5:3]) + 3'(k[2:0] != 3'd0);
	endfunction : part_len

	function automatic logic [7:0] frame_byte(input acs_frame_t kind, input logic [2:0] idx,
			input logic [1:0] lvl, input logic [5:0] k, input logic [31:0] res, input logic [7:0] mb);
		frame_byte = 8'h00;
		unique case (kind)
			FR_ANTI: frame_byte = (idx == 3'd0) ? lvl_cmd(lvl) : `ACS_NVB_ANTI; // R2 R6 R8
			FR_PART: begin
				if (idx == 3'd0) begin
					frame_byte = `ACS_SEL_LVL1; // R10
				end else if (idx == 3'd1) begin
					frame_byte = {4'(3'd2 + 3'(k[5:3])), 1'b0, k[2:0]}; // R10
				end else begin
					frame_byte = res[8*(idx-3'd2) +: 8]; // R10
				end
			end
			FR_SEL:  frame_byte = (idx == 3'd0) ? lvl_cmd(lvl) :
				(idx == 3'd1) ? `ACS_NVB_SEL : mb; // R3 R4 R7 R8 R12
			FR_RATS: frame_byte = (idx == 3'd0) ? `ACS_RATS_CMD : `ACS_RATS_PARAM; // R13
			FR_DESEL: frame_byte = `ACS_DESEL_CMD; // R14
			default: frame_byte = 8'h00;
		endcase
	endfunction : frame_byte

	function automatic logic [2:0] frame_len(input acs_frame_t kind, input logic [5:0] k);
		unique case (kind)
			FR_ANTI:  frame_len = `ACS_ANTI_LEN;
			FR_PART:  frame_len = part_len(k);
			FR_SEL:   frame_len = `ACS_SEL_LEN;
			FR_RATS:  frame_len = `ACS_RATS_LEN;
			default:  frame_len = `ACS_DESEL_LEN;
		endcase
	endfunction : frame_len

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		d = q;
		d.mwe = 1'b0;
		// verdicts stand one cycle only, so idle must not keep them
		d.done = 1'b0;
		d.fail = 1'b0;
		unique case (q.st)
			ST_IDLE: begin
				if (atqa_valid_i) begin
					d.size = atqa_i[`ACS_SIZE_POS +: 2]; // R1
					d.lvl = 2'd0;
					d.k = 6'd0;
					d.res = 32'h0000_0000;
					d.retried = 1'b0;
					d.kind = FR_ANTI; // R2
					d.idx = 3'd0;
					d.st = ST_TXF;
				end
			end
			ST_TXF: begin
				d.len = frame_len(q.kind, q.k);
				d.mra = lvl_base(q.lvl, q.idx - 3'd2);
				d.st = ST_TXW;
			end
			ST_TXW: d.st = ST_TXL; // store read takes one more edge
			ST_TXL: begin
				d.tx_valid = 1'b1;
				d.tx_data = frame_byte(q.kind, q.idx, q.lvl, q.k, q.res, mem_bus.rd_data);
				d.tx_last = (q.idx == q.len - 3'd1);
				d.tx_bits = (q.kind == FR_PART && q.idx == q.len - 3'd1) ? q.k[2:0] : 3'd0;
				d.tx_crc = (q.kind == FR_SEL) || (q.kind == FR_RATS) || (q.kind == FR_DESEL);
				d.st = ST_TXB;
			end
			ST_TXB: begin
				if (tx_ready_i) begin
					d.tx_valid = 1'b0;
					d.idx = q.idx + 3'd1;
					d.st = ST_TXF;
					if (q.tx_last) begin
						d.idx = 3'd0;
						d.bcc = 8'h00;
						d.coll = 1'b0;
						d.bad = 1'b0;
						d.st = (q.kind == FR_DESEL) ? ST_FAIL : ST_RX; // R14
					end
				end
			end
			ST_RX: begin
				if (rx_timeout_i) begin
					if (q.kind == FR_RATS && !q.retried) begin
						d.retried = `ACS_RATS_TRIES; // R13
						d.st = ST_TXF;
					end else if (q.kind == FR_RATS) begin
						d.kind = FR_DESEL; // R14
						d.st = ST_TXF;
					end else begin
						d.st = ST_FAIL;
					end
				end else if (rx_valid_i) begin
					d.idx = q.idx + 3'd1;
					d.coll = q.coll | rx_coll_i;
					unique case (q.kind)
						FR_ANTI: begin
							d.mwe = 1'b1;
							d.mwa = lvl_base(q.lvl, q.idx);
							d.mwd = rx_data_i;
							if (q.idx < 3'd4) begin
								d.bcc = q.bcc ^ rx_data_i; // R16
							end else if (rx_data_i != q.bcc) begin
								d.bad = 1'b1;
							end
							if (q.idx == 3'd0 && q.size != `ACS_SIZE_SINGLE && q.size > q.lvl &&
									rx_data_i != `ACS_CASCADE_TAG) begin
								d.bad = 1'b1; // R4
							end
						end
						default: ;
					endcase
					if (rx_last_i) begin
						d.idx = 3'd0;
						unique case (q.kind)
							FR_ANTI: begin
								if ((q.coll | rx_coll_i) && q.lvl == 2'd0) begin
									d.k = 6'd1; // R9
									d.res[0] = 1'b1; // R10
									d.kind = FR_PART;
									d.st = ST_TXF;
								end else if (d.bad) begin
									d.st = ST_FAIL;
								end else begin
									d.kind = FR_SEL; // R3 R4 R7 R8
									d.st = ST_TXF;
								end
							end
							FR_PART: begin
								// every step fixes one more bit as 1; 93 60 step is skipped
								if (q.k == `ACS_UID_BITS - 6'd1) begin
									d.k = `ACS_UID_BITS;
									d.res[31] = 1'b1;
									d.st = ST_WRB; // R11 R12
								end else begin
									d.k = q.k + 6'd1;
									d.res[q.k[4:0]] = 1'b1; // R10
									d.st = ST_TXF;
								end
							end
							FR_SEL: begin
								if (rx_data_i[`ACS_CASC_BIT] && q.lvl < 2'd2) begin // R5
									d.lvl = q.lvl + 2'd1; // R6 R8
									d.kind = FR_ANTI;
								end else begin
									d.kind = FR_RATS;
									d.retried = 1'b0;
								end
								d.st = ST_TXF;
							end
							FR_RATS: begin
								if (rx_crc_err_i && !q.retried) begin
									d.retried = `ACS_RATS_TRIES; // R15
									d.st = ST_TXF;
								end else if (rx_crc_err_i) begin
									d.kind = FR_DESEL; // R15
									d.st = ST_TXF;
								end else begin
									d.st = ST_DONE;
								end
							end
							default: d.st = ST_FAIL;
						endcase
					end
				end
			end
			ST_WRB: begin
				d.mwe = 1'b1;
				d.mwa = lvl_base(2'd0, q.idx);
				d.mwd = (q.idx == 3'd4) ? xor4(q.res) : q.res[8*q.idx[1:0] +: 8]; // R12 R16
				d.idx = q.idx + 3'd1;
				if (q.idx == 3'd4) begin
					d.idx = 3'd0;
					d.kind = FR_SEL; // R12
					d.st = ST_TXF;
				end
			end
			ST_DONE: begin
				d.done = 1'b1;
				d.st = ST_IDLE;
			end
			ST_FAIL: begin
				d.fail = 1'b1;
				d.st = ST_IDLE;
			end
			default: d.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tx_valid_o = q.tx_valid;
	assign tx_data_o  = q.tx_data;
	assign tx_last_o  = q.tx_last;
	assign tx_bits_o  = q.tx_bits;
	assign tx_crc_o   = q.tx_crc;
	assign done_o     = q.done;
	assign fail_o     = q.fail;
	assign size_o     = q.size;
endmodule : acs_reader

/* File: acs_reader_checker.sv */
// assertions on the ports of the sequencer
`timescale 1ns/100ps
module acs_reader_checker (
	// watched ports
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic       atqa_valid_i,
	input wire logic [7:0] atqa_i,
	input wire logic       tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       tx_last_o,
	input wire logic [2:0] tx_bits_o,
	input wire logic       tx_crc_o,
	input wire logic       tx_ready_i,
	input wire logic       done_o,
	input wire logic       fail_o,
	input wire logic [1:0] size_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic       idle_q, first_q;
	logic [1:0] sz_q;

	// first_q marks that the byte on offer opens a frame
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			idle_q <= 1'b1;
			first_q <= 1'b1;
			sz_q <= 2'b00;
		end else begin
			if (atqa_valid_i && idle_q) sz_q <= atqa_i[7:6];
			if (atqa_valid_i) idle_q <= 1'b0;
			if (tx_valid_o && tx_ready_i) first_q <= tx_last_o;
		end
	end

	a_size_latch: assert property (idle_q && atqa_valid_i |=> size_o == sz_q)
		else $error("size code not latched");
	a_first_anticoll: assert property (idle_q && atqa_valid_i |-> ##[3:5] (tx_valid_o && tx_data_o == 8'h93))
		else $error("level one did not open");
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
		else $error("command byte dropped before acceptance");
	a_bits_last: assert property (tx_valid_o && tx_bits_o != 3'h0 |-> tx_last_o)
		else $error("partial byte not last");
	a_one_verdict: assert property (done_o || fail_o |-> !(done_o && fail_o) ##1 !(done_o || fail_o))
		else $error("verdict not a single pulse");
	a_rats_crc: assert property (first_q && tx_valid_o && tx_data_o == 8'hE0 |-> tx_crc_o && !tx_last_o)
		else $error("request frame malformed");
	a_desel_frame: assert property (first_q && tx_valid_o && tx_data_o == 8'hC2 |-> tx_crc_o && tx_last_o)
		else $error("deselect frame malformed");
	a_desel_fail: assert property (first_q && tx_valid_o && tx_ready_i && tx_data_o == 8'hC2 |-> ##[1:20] fail_o)
		else $error("no failure after deselect");
endmodule : acs_reader_checker

/* File: acs_uid_mem.sv */
// identifier byte store: three cascade levels of five bytes, registered read
`timescale 1ns/100ps
module acs_uid_mem #(
	parameter int DEPTH = 16
) (
	// clock
	input wire logic clk_i,
	// access
	acs_mem_if.mem   mem_if
);
	logic [7:0] store_q [DEPTH];
	logic [7:0] rd_q;

	always_ff @(posedge clk_i) begin
		if (mem_if.wr_en) begin
			store_q[mem_if.wr_addr] <= mem_if.wr_data;
		end
		rd_q <= store_q[mem_if.rd_addr];
	end

	assign mem_if.rd_data = rd_q;
endmodule : acs_uid_mem

/* File: tb_top.sv */
// testbench of the anticollision and select sequencer
`timescale 1ns/100ps
module tb_top;
	// ------
	// signals
	// ------
	logic       clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       atqa_valid_i = 1'b0;
	logic [7:0] atqa_i = 8'h00;
	logic       slow = 1'b0;
	logic       tx_valid, tx_last, tx_crc, tx_ready, done, fail;
	logic       rx_valid, rx_last, rx_coll, rx_crc_err, rx_timeout;
	logic [7:0] tx_data, rx_data;
	logic [2:0] tx_bits;
	logic [1:0] size;
	logic [7:0] e[$];
	int         err_count = 0;
	int         checks_done = 0;
	int         cyc = 0;
	int         n_done, n_fail;

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	acs_reader i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .atqa_valid_i(atqa_valid_i), .atqa_i(atqa_i),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_bits_o(tx_bits), .tx_crc_o(tx_crc),
		.tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_coll_i(rx_coll),
		.rx_crc_err_i(rx_crc_err), .rx_timeout_i(rx_timeout), .done_o(done), .fail_o(fail), .size_o(size));
	acs_card_model i_card (.clk_i(clk_i), .slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
		.rx_coll_o(rx_coll), .rx_crc_err_o(rx_crc_err), .rx_timeout_o(rx_timeout));

	// pulses are counted on the falling edge, away from the edge that launches them
	always @(negedge clk_i) begin
		cyc++;
		n_done += int'(done === 1'b1);
		n_fail += int'(fail === 1'b1);
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	task chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checks_done++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	// waits for a whole frame at the card, then compares its bytes and length
	task frame(input string n, input int len);
		int i;
		i = 0;
		while (!i_card.fin && i < 400) begin
			@(negedge clk_i);
			i++;
		end
		chk({n, " length"}, 8'(len), 8'(i_card.q.size()));
		foreach (e[j]) if (j < i_card.q.size()) chk(n, e[j], i_card.q[j]);
		i_card.q.delete();
		i_card.fin = 1'b0;
		e.delete();
	endtask : frame

	task start(input logic [1:0] sz);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		n_done = 0;
		n_fail = 0;
		atqa_i = {sz, 6'h04};
		atqa_valid_i = 1'b1;
		@(negedge clk_i);
		atqa_valid_i = 1'b0;
	endtask : start

	task level(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] sak);
		logic [7:0] u[4];
		u = '{b0, c + 8'h11, c + 8'h22, c + 8'h3c};
		e = '{c, 8'h20};
		frame("anticollision", 2);
		for (int j = 0; j < 4; j++) i_card.send(u[j], 1'b0, 1'b0, 1'b0);
		i_card.send(u[0] ^ u[1] ^ u[2] ^ u[3], 1'b1, 1'b0, 1'b0);
		e = '{c, 8'h70, u[0], u[1], u[2], u[3], u[0] ^ u[1] ^ u[2] ^ u[3]};
		frame("select", 7);
		i_card.send(sak, 1'b1, 1'b0, 1'b0);
	endtask : level

	task ats_ok;
		e = '{8'hE0, 8'h01};
		frame("rats", 2);
		i_card.send(8'h05, 1'b1, 1'b0, 1'b0);
	endtask : ats_ok

	task verdict(input string n, input logic ok, input logic [1:0] sz);
		repeat (20) @(negedge clk_i);
		chk("done", 8'(ok), 8'(n_done));
		chk("fail", 8'(!ok), 8'(n_fail));
		chk("size", 8'(sz), 8'(size));
		$display("test %s finished", n);
	endtask : verdict

	// ------
	// scenarios
	// ------
	task t_single;
		start(2'b00);
		level(8'h93, 8'h12, 8'h00);
		ats_ok();
		verdict("single", 1'b1, 2'b00);
	endtask : t_single

	task t_double;
		slow = 1'b1;
		start(2'b01);
		level(8'h93, 8'h88, 8'h04);
		level(8'h95, 8'h44, 8'h00);
		ats_ok();
		verdict("double", 1'b1, 2'b01);
		slow = 1'b0;
	endtask : t_double

	task t_triple;
		start(2'b10);
		level(8'h93, 8'h88, 8'h04);
		level(8'h95, 8'h88, 8'h04);
		level(8'h97, 8'h55, 8'h00);
		ats_ok();
		verdict("triple", 1'b1, 2'b10);
	endtask : t_triple

	task t_ats_fault(input logic bad);
		start(2'b00);
		level(8'h93, 8'h21, 8'h00);
		repeat (2) begin
			e = '{8'hE0, 8'h01};
			frame("rats", 2);
			if (bad) i_card.send(8'h05, 1'b1, 1'b0, 1'b1);
			else i_card.mute();
		end
		e = '{8'hC2};
		frame("deselect", 1);
		verdict("answer fault", 1'b0, 2'b00);
	endtask : t_ats_fault

	task t_bitwise;
		start(2'b00);
		e = '{8'h93, 8'h20};
		frame("anticollision", 2);
		repeat (4) i_card.send(8'h00, 1'b0, 1'b1, 1'b0);
		i_card.send(8'h00, 1'b1, 1'b1, 1'b0);
		for (int k = 1; k <= 31; k++) begin
			e = '{8'h93, {4'(2 + k / 8), 1'b0, 3'(k % 8)}};
			for (int b = 0; b < (k + 7) / 8; b++) e.push_back((b < k / 8) ? 8'hff : 8'((1 << (k % 8)) - 1));
			frame("partial", 2 + (k + 7) / 8);
			i_card.send(8'h00, 1'b1, 1'b1, 1'b0);
		end
		// the chosen bit is always one, so the check byte of all ones is zero
		e = '{8'h93, 8'h70, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
		frame("resolved select", 7);
		i_card.send(8'h00, 1'b1, 1'b0, 1'b0);
		ats_ok();
		verdict("bitwise", 1'b1, 2'b00);
	endtask : t_bitwise

	// double size card whose level one reply lacks the cascade tag
	task t_bad_tag;
		start(2'b01);
		e = '{8'h93, 8'h20};
		frame("anticollision", 2);
		for (int j = 0; j < 4; j++) i_card.send(8'h12 + 8'(j), 1'b0, 1'b0, 1'b0);
		i_card.send(8'h00, 1'b1, 1'b0, 1'b0);
		verdict("missing tag", 1'b0, 2'b01);
		chk("frames after bad tag", 8'h00, 8'(i_card.q.size()));
	endtask : t_bad_tag

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		t_single();
		t_double();
		t_triple();
		t_ats_fault(1'b0);
		t_ats_fault(1'b1);
		t_bitwise();
		t_bad_tag();
		report_and_stop();
	end
endmodule : tb_top

bind acs_reader acs_reader_checker i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .atqa_valid_i(atqa_valid_i),
	.atqa_i(atqa_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_bits_o(tx_bits_o),
	.tx_crc_o(tx_crc_o), .tx_ready_i(tx_ready_i), .done_o(done_o), .fail_o(fail_o), .size_o(size_o));
